// ---- codec_gain_routing.v ----
`include "codec_gain_map.vh"
`default_nettype none

module codec_gain_routing
#(
  parameter [1:0] CHIP_ADDR = `CHIP_ADDR_DEFAULT
)
(
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        POWER_DOWN_PIN_N,
  input  wire        LRCK,
  input  wire        CSN,
  input  wire        CCLK,
  input  wire        CDTI,
  output reg         CDTO,
  output reg         CDTO_OE,
  input  wire [1:0]  ZERO_CROSS,
  output reg  [5:0]  LEFT_ANALOG_GAIN,
  output reg  [5:0]  RIGHT_ANALOG_GAIN,
  output wire [12:0] LEFT_LADDER_LEVEL,
  output wire [12:0] RIGHT_LADDER_LEVEL,
  output wire [12:0] LEFT_OUT_LEVEL,
  output wire [12:0] RIGHT_OUT_LEVEL,
  output reg         ADC_OUTPUT_ZERO,
  output reg         SOFT_MUTE,
  output reg  [1:0]  SERIAL_OUT_SOURCE,
  output reg  [1:0]  PLAYBACK_SOURCE,
  output reg  [1:0]  TRANSMITTER_SOURCE,
  output reg         TRANSMIT_OUTPUT_THREE_SEL,
  output reg  [7:0]  CLOCK_MODE_SETUP
);

  function [12:0] ladder_of;
    input [6:0] code;
    reg   [13:0] prod;
    begin
      prod      = ({9'h000, code[3:0], 1'b0} + `LADDER_OFFSET) << code[6:4];
      prod      = prod - `LADDER_OFFSET;
      ladder_of = prod[12:0];
    end
  endfunction

  function [12:0] out_scale_of;
    input [7:0] code;
    reg   [20:0] prod;
    begin
      prod         = ({13'h0000, code} + 21'h1) * {8'h00, `OUT_SCALE_STEP};
      out_scale_of = (code == 8'h00) ? 13'h0000 : prod[12:0];
    end
  endfunction

  // Two-flop synchronisers for LRCK, CDTI, CCLK, CSN and POWER_DOWN_PIN_N.
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  reg       cclk_d_ff;
  reg       lrck_d_ff;
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sync1_ff  <= 5'h07;
      sync2_ff  <= 5'h07;
      cclk_d_ff <= 1'b1;
      lrck_d_ff <= 1'b0;
    end
    else
    begin
      sync1_ff  <= {LRCK, CDTI, CCLK, CSN, POWER_DOWN_PIN_N};
      sync2_ff  <= sync1_ff;
      cclk_d_ff <= sync2_ff[2];
      lrck_d_ff <= sync2_ff[4];
    end
  end
  wire pdn_n     = sync2_ff[0];
  wire csn_s     = sync2_ff[1];
  wire cclk_s    = sync2_ff[2];
  wire cdti_s    = sync2_ff[3];
  wire tick      = sync2_ff[4] & ~lrck_d_ff;
  wire cclk_rise = cclk_s & ~cclk_d_ff;
  wire cclk_fall = ~cclk_s & cclk_d_ff;

  // Registers; power-down pin low returns them to defaults.
  reg [7:0] power_ff;
  reg [7:0] run_ff;
  reg [7:0] volume_ff;
  reg [7:0] gain_ff [0:1];
  reg [7:0] out_level_ff [0:1];
  reg [7:0] routing_ff;
  reg [7:0] clock_mode_ff;

  // Serial frame: chip address(2), write flag(1), address(5), data(8), MSB first.
  reg [15:0] shift_ff;
  reg [4:0]  count_ff;
  reg [7:0]  rdata_ff;
  wire       frame_write = shift_ff[5];
  wire [4:0] frame_addr  = shift_ff[4:0];
  wire       addr_hit    = (shift_ff[7:6] == CHIP_ADDR);
  wire       wr_now      = cclk_rise && !csn_s && (count_ff == 5'd15)
                           && shift_ff[14:13] == CHIP_ADDR && shift_ff[12];
  wire [4:0] wr_addr     = shift_ff[11:7];
  wire [7:0] wr_data     = {shift_ff[6:0], cdti_s};

  reg [7:0] rd_mux;
  always @*
  begin
    case (frame_addr)
      `ADDR_POWER_CTRL:      rd_mux = power_ff;
      `ADDR_RUN_CTRL:        rd_mux = run_ff;
      `ADDR_VOLUME_CTRL:     rd_mux = volume_ff;
      `ADDR_LEFT_GAIN:       rd_mux = gain_ff[0];
      `ADDR_RIGHT_GAIN:      rd_mux = gain_ff[1];
      `ADDR_LEFT_OUT_LEVEL:  rd_mux = out_level_ff[0];
      `ADDR_RIGHT_OUT_LEVEL: rd_mux = out_level_ff[1];
      `ADDR_SOURCE_ROUTING:  rd_mux = routing_ff;
      `ADDR_CLOCK_MODE:      rd_mux = clock_mode_ff;
      default:               rd_mux = 8'h00;
    endcase
  end

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      shift_ff <= 16'h0000;
      count_ff <= 5'h00;
      rdata_ff <= 8'h00;
      CDTO     <= 1'b0;
      CDTO_OE  <= 1'b0;
    end
    else if (csn_s)
    begin
      count_ff <= 5'h00;
      CDTO     <= 1'b0;
      CDTO_OE  <= 1'b0;
    end
    else
    begin
      if (cclk_rise)
      begin
        shift_ff <= {shift_ff[14:0], cdti_s};
        if (count_ff != 5'd16)
          count_ff <= count_ff + 5'h01;
        if (count_ff == 5'd7)
          rdata_ff <= 8'h00;
      end
      if (count_ff == 5'd8 && cclk_fall && !frame_write && addr_hit)
      begin
        CDTO     <= rd_mux[7];
        rdata_ff <= {rd_mux[6:0], 1'b0};
        CDTO_OE  <= 1'b1;
      end
      else if (CDTO_OE && cclk_fall)
      begin
        CDTO     <= rdata_ff[7];
        rdata_ff <= {rdata_ff[6:0], 1'b0};
        CDTO_OE  <= (count_ff != 5'd16);
      end
    end
  end

  integer i;
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      power_ff      <= `RST_POWER_CTRL;
      run_ff        <= `RST_RUN_CTRL;
      volume_ff     <= `RST_VOLUME_CTRL;
      routing_ff    <= `RST_SOURCE_ROUTING;
      clock_mode_ff <= `RST_CLOCK_MODE;
      for (i = 0; i < 2; i = i + 1)
      begin
        gain_ff[i]      <= `RST_GAIN;
        out_level_ff[i] <= `RST_OUT_LEVEL;
      end
    end
    else if (!pdn_n)
    begin
      power_ff      <= `RST_POWER_CTRL;
      run_ff        <= `RST_RUN_CTRL;
      volume_ff     <= `RST_VOLUME_CTRL;
      routing_ff    <= `RST_SOURCE_ROUTING;
      clock_mode_ff <= `RST_CLOCK_MODE;
      for (i = 0; i < 2; i = i + 1)
      begin
        gain_ff[i]      <= `RST_GAIN;
        out_level_ff[i] <= `RST_OUT_LEVEL;
      end
    end
    else if (wr_now)
    begin
      case (wr_addr)
        `ADDR_POWER_CTRL:      power_ff        <= wr_data & `MASK_POWER_CTRL;
        `ADDR_RUN_CTRL:        run_ff          <= wr_data & `MASK_RUN_CTRL;
        `ADDR_VOLUME_CTRL:     volume_ff       <= wr_data;
        `ADDR_LEFT_GAIN:       gain_ff[0]      <= wr_data;
        `ADDR_RIGHT_GAIN:      gain_ff[1]      <= wr_data;
        `ADDR_LEFT_OUT_LEVEL:  out_level_ff[0] <= wr_data;
        `ADDR_RIGHT_OUT_LEVEL: out_level_ff[1] <= wr_data;
        `ADDR_SOURCE_ROUTING:  routing_ff      <= wr_data & `MASK_SOURCE_ROUTING;
        `ADDR_CLOCK_MODE:      clock_mode_ff   <= wr_data;
        default:               clock_mode_ff   <= clock_mode_ff;
      endcase
    end
  end

  wire rec_on  = pdn_n & power_ff[`BIT_REC_POWER] & run_ff[`BIT_REC_RUN];
  wire play_on = pdn_n & power_ff[`BIT_PLAY_POWER] & run_ff[`BIT_PLAY_RUN];
  wire zc_gate = volume_ff[`BIT_ZERO_CROSS_GATE];
  wire [11:0] zc_limit = `ZC_TIMEOUT_BASE << volume_ff[`POS_TIMEOUT_SEL +: 2];

  // Gated gain code per channel and its zero-cross timeout counter.
  reg [7:0]  applied_ff [0:1];
  reg [11:0] wait_ff [0:1];
  reg [9:0]  rec_count_ff;
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rec_count_ff <= 10'h000;
      for (i = 0; i < 2; i = i + 1)
      begin
        applied_ff[i] <= `RST_GAIN;
        wait_ff[i]    <= 12'h000;
      end
    end
    else
    begin
      if (!rec_on)
        rec_count_ff <= 10'h000;
      else if (tick && rec_count_ff != `REC_ZERO_SAMPLES)
        rec_count_ff <= rec_count_ff + 10'h001;
      for (i = 0; i < 2; i = i + 1)
      begin
        if (applied_ff[i] == gain_ff[i])
          wait_ff[i] <= 12'h000;
        else if (!zc_gate || ZERO_CROSS[i] || wait_ff[i] == zc_limit)
        begin
          applied_ff[i] <= gain_ff[i];
          wait_ff[i]    <= 12'h000;
        end
        else if (tick)
          wait_ff[i] <= wait_ff[i] + 12'h001;
      end
    end
  end

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      LEFT_ANALOG_GAIN          <= 6'h00;
      RIGHT_ANALOG_GAIN         <= 6'h00;
      ADC_OUTPUT_ZERO           <= 1'b1;
      SOFT_MUTE                 <= 1'b0;
      SERIAL_OUT_SOURCE         <= `SRC_CONVERTER;
      PLAYBACK_SOURCE           <= `SRC_CONVERTER;
      TRANSMITTER_SOURCE        <= 2'b00;
      TRANSMIT_OUTPUT_THREE_SEL <= 1'b0;
      CLOCK_MODE_SETUP          <= `RST_CLOCK_MODE;
    end
    else
    begin
      LEFT_ANALOG_GAIN   <= analog_of(applied_ff[0]);
      RIGHT_ANALOG_GAIN  <= analog_of(applied_ff[1]);
      ADC_OUTPUT_ZERO    <= !rec_on || (rec_count_ff != `REC_ZERO_SAMPLES);
      SOFT_MUTE          <= volume_ff[`BIT_SOFT_MUTE];
      SERIAL_OUT_SOURCE  <= routing_ff[`POS_SERIAL_OUT_SRC +: 2];
      PLAYBACK_SOURCE    <= routing_ff[`POS_PLAY_SRC +: 2];
      TRANSMITTER_SOURCE <= routing_ff[`POS_TX_SRC +: 2];
      TRANSMIT_OUTPUT_THREE_SEL <= power_ff[`BIT_TX_POWER]
        && (routing_ff[`POS_TX_SRC +: 2] == `TX_SRC_THIRD_OUT);
      CLOCK_MODE_SETUP   <= clock_mode_ff;
    end
  end

  function [5:0] analog_of;
    input [7:0] code;
    reg   [7:0] diff;
    begin
      if (code < `GAIN_ANALOG_BASE)
        analog_of = 6'h00;
      else
      begin
        diff      = ((code > `GAIN_ANALOG_MAX) ? `GAIN_ANALOG_MAX : code)
                    - `GAIN_ANALOG_BASE;
        analog_of = diff[5:0];
      end
    end
  endfunction

  // Ladder target; codes at or above 128 leave the ladder at unity.
  wire [12:0] ladder_tgt_l = applied_ff[0][7] ? `LADDER_UNITY : ladder_of(applied_ff[0][6:0]);
  wire [12:0] ladder_tgt_r = applied_ff[1][7] ? `LADDER_UNITY : ladder_of(applied_ff[1][6:0]);

  level_ramp u_ladder_l
  (
    .clk        (CLK),
    .rst        (SYS_RST),
    .tick       (tick),
    .load       (!rec_on),
    .load_value (13'h0000),
    .target     (ladder_tgt_l),
    .level_ff   (LEFT_LADDER_LEVEL)
  );

  level_ramp u_ladder_r
  (
    .clk        (CLK),
    .rst        (SYS_RST),
    .tick       (tick),
    .load       (!rec_on),
    .load_value (13'h0000),
    .target     (ladder_tgt_r),
    .level_ff   (RIGHT_LADDER_LEVEL)
  );

  level_ramp u_out_l
  (
    .clk        (CLK),
    .rst        (SYS_RST),
    .tick       (tick),
    .load       (!play_on),
    .load_value (`OUT_SCALE_FULL),
    .target     (out_scale_of(out_level_ff[0])),
    .level_ff   (LEFT_OUT_LEVEL)
  );

  level_ramp u_out_r
  (
    .clk        (CLK),
    .rst        (SYS_RST),
    .tick       (tick),
    .load       (!play_on),
    .load_value (`OUT_SCALE_FULL),
    .target     (out_scale_of(out_level_ff[1])),
    .level_ff   (RIGHT_OUT_LEVEL)
  );

endmodule

`default_nettype wire

// ---- codec_gain_map.vh ----
`ifndef CODEC_GAIN_MAP_VH
`define CODEC_GAIN_MAP_VH

`define ADDR_POWER_CTRL      5'h00
`define ADDR_RUN_CTRL        5'h01
`define ADDR_VOLUME_CTRL     5'h03
`define ADDR_LEFT_GAIN       5'h04
`define ADDR_RIGHT_GAIN      5'h05
`define ADDR_LEFT_OUT_LEVEL  5'h06
`define ADDR_RIGHT_OUT_LEVEL 5'h07
`define ADDR_SOURCE_ROUTING  5'h08
`define ADDR_CLOCK_MODE      5'h09

`define RST_POWER_CTRL       8'h1f
`define RST_RUN_CTRL         8'h00
`define RST_VOLUME_CTRL      8'h19
`define RST_GAIN             8'h7f
`define RST_OUT_LEVEL        8'hff
`define RST_SOURCE_ROUTING   8'h00
`define RST_CLOCK_MODE       8'h44

`define MASK_POWER_CTRL      8'h1f
`define MASK_RUN_CTRL        8'h03
`define MASK_SOURCE_ROUTING  8'h3f

`define BIT_PLAY_POWER       0
`define BIT_REC_POWER        1
`define BIT_TX_POWER         3
`define BIT_PLAY_RUN         0
`define BIT_REC_RUN          1
`define BIT_ZERO_CROSS_GATE  4
`define BIT_SOFT_MUTE        6
`define POS_TIMEOUT_SEL      2
`define POS_TX_SRC           0
`define POS_SERIAL_OUT_SRC   2
`define POS_PLAY_SRC         4

`define SRC_CONVERTER        2'b00
`define SRC_SERIAL_IN        2'b01
`define SRC_RECEIVER         2'b10
`define TX_SRC_THIRD_OUT     2'b10

`define GAIN_ANALOG_BASE     8'h80
`define GAIN_ANALOG_MAX      8'ha4
`define LADDER_UNITY         13'd8031
`define LADDER_OFFSET        14'd33
`define OUT_SCALE_STEP       13'd29
`define OUT_SCALE_FULL       13'd7424
`define REC_ZERO_SAMPLES     10'd516
`define ZC_TIMEOUT_BASE      12'd256
`define CHIP_ADDR_DEFAULT    2'b00

`endif

// ---- level_ramp.v ----
`default_nettype none

// Moves a level one step per sample tick toward its target; load forces it at once.
module level_ramp
(
  input  wire        clk,
  input  wire        rst,
  input  wire        tick,
  input  wire        load,
  input  wire [12:0] load_value,
  input  wire [12:0] target,
  output reg  [12:0] level_ff
);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      level_ff <= 13'h0000;
    else if (load)
      level_ff <= load_value;
    else if (tick && (level_ff < target))
      level_ff <= level_ff + 13'h0001;
    else if (tick && (level_ff > target))
      level_ff <= level_ff - 13'h0001;
  end

endmodule

`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
// Serial control master; the clock idles high and only toggles inside a frame.
module host_model
(
  input  wire logic CLK,
  input  wire logic CDTO,
  output logic      CSN,
  output logic      CCLK,
  output logic      CDTI
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    CSN = 1'b1;
    CCLK = 1'b1;
    CDTI = 1'b0;
  end
  task xfer(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge CLK) CSN <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      repeat (8) @(posedge CLK);
      CCLK <= 1'b0;
      CDTI <= f[i];
      repeat (8) @(posedge CLK);
      CCLK <= 1'b1;
      if (i < 8)
        rd = {rd[6:0], CDTO};
    end
    repeat (8) @(posedge CLK);
    CSN <= 1'b1;
    CDTI <= ~f[0];
    repeat (8) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ---- gain_routing_chk.sv ----
`default_nettype none
module gain_routing_chk
(
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        LRCK,
  input wire logic        CSN,
  input wire logic        CDTO_OE,
  input wire logic [5:0]  LEFT_ANALOG_GAIN,
  input wire logic [12:0] LEFT_LADDER_LEVEL,
  input wire logic [12:0] RIGHT_LADDER_LEVEL,
  input wire logic [12:0] LEFT_OUT_LEVEL,
  input wire logic [12:0] RIGHT_OUT_LEVEL,
  input wire logic [1:0]  TRANSMITTER_SOURCE,
  input wire logic        TRANSMIT_OUTPUT_THREE_SEL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] lrck_hist_ff;
  wire        tick_seen = |(lrck_hist_ff[5:0] & ~lrck_hist_ff[6:1]);
  always_ff @(posedge CLK or posedge SYS_RST)
    if (SYS_RST)
      lrck_hist_ff <= '0;
    else
      lrck_hist_ff <= {lrck_hist_ff[5:0], LRCK};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence out_moved;
    $changed(LEFT_OUT_LEVEL) && LEFT_OUT_LEVEL != 13'd7424;
  endsequence
  sequence read_idle;
    CSN [*4];
  endsequence
  AST_GAIN_CAP:
  assert property (LEFT_ANALOG_GAIN <= 6'd36)
    else $error("analog gain above the top step");
  AST_LADDER_CAP:
  assert property (LEFT_LADDER_LEVEL <= 13'd8031)
    else $error("ladder level above unity");
  AST_LADDER_STEP:
  assert property ($changed(RIGHT_LADDER_LEVEL) |-> RIGHT_LADDER_LEVEL == 13'd0
    || 13'(RIGHT_LADDER_LEVEL - $past(RIGHT_LADDER_LEVEL)) inside {13'd1, 13'h1fff})
    else $error("ladder level jumped");
  AST_OUT_CAP:
  assert property (RIGHT_OUT_LEVEL <= 13'd7424)
    else $error("output level above full scale");
  AST_OUT_STEP:
  assert property (out_moved |-> 13'(LEFT_OUT_LEVEL - $past(LEFT_OUT_LEVEL))
    inside {13'd1, 13'h1fff})
    else $error("output level moved by more than one step");
  AST_OUT_TICK:
  assert property (out_moved |-> tick_seen)
    else $error("output level moved without a sample tick");
  AST_TX3_SEL:
  assert property (TRANSMIT_OUTPUT_THREE_SEL |-> TRANSMITTER_SOURCE == 2'b10)
    else $error("third output selected with wrong source");
  AST_READ_IDLE:
  assert property (read_idle |-> !CDTO_OE)
    else $error("read data driven while deselected");
endmodule
bind codec_gain_routing gain_routing_chk chk
(
  .CLK(CLK), .SYS_RST(SYS_RST), .LRCK(LRCK), .CSN(CSN), .CDTO_OE(CDTO_OE),
  .LEFT_ANALOG_GAIN(LEFT_ANALOG_GAIN), .LEFT_LADDER_LEVEL(LEFT_LADDER_LEVEL),
  .RIGHT_LADDER_LEVEL(RIGHT_LADDER_LEVEL), .LEFT_OUT_LEVEL(LEFT_OUT_LEVEL),
  .RIGHT_OUT_LEVEL(RIGHT_OUT_LEVEL), .TRANSMITTER_SOURCE(TRANSMITTER_SOURCE),
  .TRANSMIT_OUTPUT_THREE_SEL(TRANSMIT_OUTPUT_THREE_SEL)
);
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       pdn_n = 1'b1;
  logic       lrck = 1'b0;
  logic [1:0] zc = 2'b00;
  wire        csn;
  wire        cclk;
  wire        cdti;
  wire        cdto;
  int         miscompares = 0;
  int         cmp_count = 0;
  always #20 clk = ~clk;
  host_model host (.CLK(clk), .CDTO(cdto), .CSN(csn), .CCLK(cclk), .CDTI(cdti));
  codec_gain_routing uut
  (
    .CLK(clk), .SYS_RST(sys_rst), .POWER_DOWN_PIN_N(pdn_n), .LRCK(lrck),
    .CSN(csn), .CCLK(cclk), .CDTI(cdti), .CDTO(cdto), .CDTO_OE(), .ZERO_CROSS(zc),
    .LEFT_ANALOG_GAIN(), .RIGHT_ANALOG_GAIN(), .LEFT_LADDER_LEVEL(),
    .RIGHT_LADDER_LEVEL(), .LEFT_OUT_LEVEL(), .RIGHT_OUT_LEVEL(),
    .ADC_OUTPUT_ZERO(), .SOFT_MUTE(), .SERIAL_OUT_SOURCE(), .PLAYBACK_SOURCE(),
    .TRANSMITTER_SOURCE(), .TRANSMIT_OUTPUT_THREE_SEL(), .CLOCK_MODE_SETUP()
  );
  task end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer({2'b00, 1'b1, a, d}, unused);
  endtask
  task rd(input logic [4:0] a, output logic [7:0] d);
    host.xfer({2'b00, 1'b0, a, 8'h00}, d);
  endtask
  task ticks(input int n);
    repeat (n)
    begin
      @(posedge clk) lrck <= 1'b1;
      repeat (4) @(posedge clk);
      lrck <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task sc_defaults;
    logic [7:0] d;
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7424)
    `CHK(uut.CLOCK_MODE_SETUP, 8'h44)
    rd(5'h06, d);
    `CHK(d, 8'hff)
    rd(5'h07, d);
    `CHK(d, 8'hff)
    rd(5'h08, d);
    `CHK(d, 8'h00)
    rd(5'h09, d);
    `CHK(d, 8'h44)
    rd(5'h1f, d);
    `CHK(d, 8'h00)
  endtask
  task sc_gain;
    logic [7:0] c [5];
    c = '{8'ha4, 8'hff, 8'ha3, 8'h81, 8'h80};
    wr(5'h03, 8'h49);
    `CHK(uut.SOFT_MUTE, 1'b1)
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7424)
    wr(5'h04, 8'h02);
    wr(5'h01, 8'h03);
    ticks(2);
    `CHK(uut.LEFT_LADDER_LEVEL, 13'd2)
    ticks(3);
    `CHK(uut.LEFT_LADDER_LEVEL, 13'd4)
    `CHK(uut.ADC_OUTPUT_ZERO, 1'b1)
    wr(5'h04, 8'h11);
    ticks(40);
    `CHK(uut.LEFT_LADDER_LEVEL, 13'd37)
    ticks(455);
    `CHK(uut.ADC_OUTPUT_ZERO, 1'b1)
    ticks(20);
    `CHK(uut.ADC_OUTPUT_ZERO, 1'b0)
    foreach (c[i])
    begin
      wr(5'h05, c[i]);
      `CHK(uut.RIGHT_ANALOG_GAIN, (c[i] > 8'ha3) ? 6'd36 : 6'(c[i] - 8'h80))
    end
  endtask
  task sc_out;
    wr(5'h06, 8'hfe);
    ticks(10);
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7414)
    ticks(25);
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7395)
    `CHK(uut.RIGHT_OUT_LEVEL, 13'd7424)
    wr(5'h01, 8'h02);
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7424)
    wr(5'h01, 8'h03);
    ticks(5);
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7419)
    wr(5'h00, 8'h1e);
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7424)
    wr(5'h00, 8'h1f);
    ticks(3);
    `CHK(uut.LEFT_OUT_LEVEL, 13'd7421)
  endtask
  task sc_route;
    logic [7:0] d;
    for (int k = 0; k < 3; k++)
    begin
      wr(5'h08, {2'b11, 2'(k), 2'(k), 2'(k)});
      rd(5'h08, d);
      `CHK(d, {2'b00, 2'(k), 2'(k), 2'(k)})
      `CHK(uut.SERIAL_OUT_SOURCE, 2'(k))
      `CHK(uut.PLAYBACK_SOURCE, 2'(k))
      `CHK(uut.TRANSMITTER_SOURCE, 2'(k))
      `CHK(uut.TRANSMIT_OUTPUT_THREE_SEL, k == 2)
    end
    host.xfer({2'b01, 1'b1, 5'h08, 8'h00}, d);
    `CHK(uut.SERIAL_OUT_SOURCE, 2'b10)
  endtask
  task sc_zero_cross;
    wr(5'h03, 8'h19);
    wr(5'h05, 8'ha4);
    `CHK(uut.RIGHT_ANALOG_GAIN, 6'd0)
    zc <= 2'b10;
    @(posedge clk);
    zc <= 2'b00;
    repeat (4) @(posedge clk);
    `CHK(uut.RIGHT_ANALOG_GAIN, 6'd36)
  endtask
  task sc_power_pin;
    logic [7:0] d;
    wr(5'h07, 8'h10);
    pdn_n <= 1'b0;
    repeat (10) @(posedge clk);
    pdn_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(5'h07, d);
    `CHK(d, 8'hff)
    rd(5'h08, d);
    `CHK(d, 8'h00)
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    sc_defaults;
    sc_gain;
    sc_out;
    sc_route;
    sc_zero_cross;
    sc_power_pin;
    end_sim;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule
`default_nettype wire
